// file: ptp_cfg_pkg.sv
// Constants shared by the time-sync message configuration and classification logic.
package ptp_cfg_pkg;

	// ----------------------------------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [11:0] IDX_CFG_ONE = 12'h514;
	localparam logic [11:0] IDX_CFG_TWO = 12'h516;
	localparam logic [13:0] ADDR_CFG_ONE = {IDX_CFG_ONE, 2'b00};
	localparam logic [13:0] ADDR_CFG_TWO = {IDX_CFG_TWO, 2'b00};

	// ----------------------------------------------------------------
	// Field positions of the first configuration register
	// ----------------------------------------------------------------
	localparam int B_ONE_STEP = 0;
	localparam int B_HOST_MASTER = 1;
	localparam int B_TC_P2P = 2;
	localparam int B_DET_IPV6 = 3;
	localparam int B_DET_IPV4 = 4;
	localparam int B_DET_ETH = 5;
	localparam int B_SYNC_MODE = 6;
	localparam int B_PROFILE = 7;

	// ----------------------------------------------------------------
	// Field positions of the second configuration register
	// ----------------------------------------------------------------
	localparam int B_SYNC_ASSOC = 9;
	localparam int B_ALL_TOP_QUEUE = 10;
	localparam int B_ALT_MASTER = 11;
	localparam int B_UNICAST = 12;

	// ----------------------------------------------------------------
	// Reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_CFG_ONE = 16'h0039;
	localparam logic [15:0] RST_CFG_TWO = 16'h1000;
	localparam logic [15:0] MASK_CFG_ONE = 16'h00FF;
	localparam logic [15:0] MASK_CFG_TWO = 16'h1E00;

	// ----------------------------------------------------------------
	// Message types, transports and UDP ports
	// ----------------------------------------------------------------
	localparam logic [3:0] MSG_SYNC = 4'h0;
	localparam logic [3:0] MSG_DELAY_REQ = 4'h1;
	localparam logic [3:0] MSG_FOLLOW_UP = 4'h8;
	localparam logic [3:0] MSG_EVENT_LIMIT = 4'h8;
	localparam logic [15:0] UDP_PORT_EVENT = 16'h013F;
	localparam logic [15:0] UDP_PORT_GENERAL = 16'h0140;

	typedef enum logic [1:0] {
		TR_OTHER = 2'h0,
		TR_ETH = 2'h1,
		TR_IPV4 = 2'h2,
		TR_IPV6 = 2'h3
	} transport_e;

endpackage : ptp_cfg_pkg

// file: ptp_frame_classifier.sv
// Combinational forwarding decision for one frame descriptor.
`timescale 1ns/100ps
module ptp_frame_classifier
	import ptp_cfg_pkg::*;
(
	// Configuration.
	input wire logic [15:0] cfg_one,
	input wire logic [15:0] cfg_two,
	// Frame descriptor.
	input wire transport_e transport,
	input wire logic [3:0] msg_type,
	input wire logic reserved_addr,
	input wire logic [15:0] udp_port,
	input wire logic from_host,
	input wire logic same_domain,
	input wire logic from_active_master,
	input wire logic assoc_match,
	// Decision.
	output logic is_ptp,
	output logic to_host,
	output logic to_nonhost,
	output logic use_lookup,
	output logic drop,
	output logic top_queue,
	output logic hdr_edit,
	output logic ts_insert
);

	logic sync_on;
	logic profile_on;
	logic path_ok;
	logic port_ok;
	logic unicast;
	logic event_msg;
	logic sync_or_dreq;

	// Mode qualifiers and frame recognition.
	always_comb begin
		sync_on = cfg_one[B_SYNC_MODE];
		profile_on = cfg_one[B_SYNC_MODE] & cfg_one[B_PROFILE];
		port_ok = (udp_port == UDP_PORT_EVENT) || (udp_port == UDP_PORT_GENERAL);
		unique case (transport)
			TR_ETH: path_ok = cfg_one[B_DET_ETH];
			TR_IPV4: path_ok = cfg_one[B_DET_IPV4] & port_ok;
			TR_IPV6: path_ok = cfg_one[B_DET_IPV6] & port_ok;
			default: path_ok = 1'b0;
		endcase
		unicast = !reserved_addr && cfg_two[B_UNICAST];
		event_msg = msg_type < MSG_EVENT_LIMIT;
		sync_or_dreq = (msg_type == MSG_SYNC) || (msg_type == MSG_DELAY_REQ);
		is_ptp = sync_on && path_ok && (reserved_addr || unicast);
	end

	// Destination, queue and rewrite choices.
	always_comb begin
		to_host = 1'b0;
		to_nonhost = 1'b0;
		use_lookup = 1'b1;
		top_queue = is_ptp && (cfg_two[B_ALL_TOP_QUEUE] || event_msg);
		hdr_edit = is_ptp && !profile_on;
		ts_insert = is_ptp && event_msg;
		if (is_ptp && unicast) begin
			use_lookup = 1'b1;
		end else if (is_ptp && profile_on) begin
			use_lookup = 1'b0;
			to_host = 1'b1;
		end else if (is_ptp) begin
			use_lookup = 1'b0;
			to_host = !from_host;
			to_nonhost = 1'b1;
			if (sync_or_dreq && !from_host && from_active_master) begin
				if (cfg_two[B_ALT_MASTER]) begin
					to_host = 1'b0;
					to_nonhost = 1'b1;
				end else begin
					to_host = 1'b0;
					to_nonhost = !same_domain;
				end
			end
			if ((msg_type == MSG_FOLLOW_UP) && cfg_two[B_SYNC_ASSOC]) begin
				to_host = to_host && assoc_match;
			end
		end
		drop = is_ptp && !use_lookup && !to_host && !to_nonhost;
	end

endmodule : ptp_frame_classifier

// file: ptp_message_handling_config.sv
// Time-sync message configuration registers on AHB-Lite and per-frame forwarding decisions.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
// Contract
// - Profile-variant bit 7 acts only while time-sync mode bit 6 is set.
// - Profile variant sends every time-sync message to host, headers untouched; the code sends unicast ones by table lookup instead.
// - Time-sync mode identifies message types and gives them special forwarding.
// - Time-sync mode may rewrite headers and insert timestamps.
// - Mode bit turns the internal time-sync clock on; resets to zero.
// - Time-sync mode uses the timestamp-carrying tail tag on the host port.
// - Raw Ethernet time-sync detection only while bit 5 set; resets to one.
// - IPv4/UDP detection only while bit 4 set; resets to one.
// - IPv6/UDP detection only while bit 3 set; resets to one.
// - Bit 2 picks peer-to-peer (one) or end-to-end (zero); resets zero.
// - Bit 1 makes host port master (one) or slave (zero); resets zero.
// - Bit 0 picks one-step (one) or two-step (zero); resets one.
// - Unicast bit 12: port 319/320 without reserved address uses table lookup.
// - Unicast disabled: only multicast-addressed frames count as time-sync.
// - Alternate master on: same-domain Sync/Delay_Req from master go to non-host ports.
// - Alternate master off: such frames skip host; other domains reach non-host ports.
// - Bit 10 puts all messages in top queue; otherwise event messages only.
// - Bit 9 pairs Follow_up with Sync; host gets it only on matching identifiers; the code's profile variant sends it to host regardless.
module ptp_message_handling_config
	import ptp_cfg_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Frame descriptor from the forwarding fabric.
	input wire logic desc_valid,
	input wire transport_e desc_transport,
	input wire logic [3:0] desc_msg_type,
	input wire logic desc_reserved_addr,
	input wire logic [15:0] desc_udp_port,
	input wire logic desc_from_host,
	input wire logic desc_same_domain,
	input wire logic desc_from_active_master,
	input wire logic [7:0] desc_domain,
	input wire logic [15:0] desc_seq_id,
	input wire logic [15:0] desc_src_port,
	// Forwarding decision.
	output logic dec_valid,
	output logic dec_is_ptp,
	output logic dec_to_host,
	output logic dec_to_nonhost,
	output logic dec_use_lookup,
	output logic dec_drop,
	output logic dec_top_queue,
	output logic dec_hdr_edit,
	output logic dec_ts_insert,
	// Static mode outputs.
	output logic ptp_clock_en,
	output logic tail_tag_ts,
	output logic tc_p2p,
	output logic host_master,
	output logic one_step
);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------

	logic [15:0] cfg_one_q;
	logic [15:0] cfg_one_d;
	logic [15:0] cfg_two_q;
	logic [15:0] cfg_two_d;
	logic wr_one_q;
	logic wr_two_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	logic hresp_q;
	logic addr_phase;

	// An access is taken when selected, non-idle and the bus is ready.
	assign addr_phase = hsel && htrans[1] && hready;

	// Remember which register a write targets until its data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_one_q <= 1'b0;
			wr_two_q <= 1'b0;
		end else if (hready) begin
			wr_one_q <= addr_phase && hwrite && (haddr[13:0] == ADDR_CFG_ONE);
			wr_two_q <= addr_phase && hwrite && (haddr[13:0] == ADDR_CFG_TWO);
		end
	end

	// Next register values with the pending write applied.
	always_comb begin
		cfg_one_d = cfg_one_q;
		cfg_two_d = cfg_two_q;
		if (wr_one_q) begin
			cfg_one_d = hwdata[15:0] & MASK_CFG_ONE;
		end
		if (wr_two_q) begin
			cfg_two_d = hwdata[15:0] & MASK_CFG_TWO;
		end
	end

	// Configuration registers, reserved bits held at zero.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_one_q <= RST_CFG_ONE;
			cfg_two_q <= RST_CFG_TWO;
		end else begin
			cfg_one_q <= cfg_one_d;
			cfg_two_q <= cfg_two_d;
		end
	end

	// Read data is loaded from next values so a read right after a write sees it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (addr_phase && !hwrite && (haddr[13:0] == ADDR_CFG_ONE)) begin
			hrdata_q <= {16'h0000, cfg_one_d};
		end else if (addr_phase && !hwrite && (haddr[13:0] == ADDR_CFG_TWO)) begin
			hrdata_q <= {16'h0000, cfg_two_d};
		end else begin
			hrdata_q <= 32'h0000_0000;
		end
	end

	// The slave never stalls and always answers OKAY.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;

	// ----------------------------------------------------------------
	// Static mode outputs
	// ----------------------------------------------------------------

	// Clock enable and tail tag follow the mode bit; method bits drive the timing engine.
	assign ptp_clock_en = cfg_one_q[B_SYNC_MODE];
	assign tail_tag_ts = cfg_one_q[B_SYNC_MODE];
	assign tc_p2p = cfg_one_q[B_TC_P2P];
	assign host_master = cfg_one_q[B_HOST_MASTER];
	assign one_step = cfg_one_q[B_ONE_STEP];

	// ----------------------------------------------------------------
	// Sync and Follow_up association
	// ----------------------------------------------------------------

	logic [39:0] sync_key_q;
	logic sync_key_valid_q;
	logic [39:0] desc_key;
	logic assoc_match;
	logic cls_is_ptp;
	logic cls_to_host;
	logic cls_to_nonhost;
	logic cls_use_lookup;
	logic cls_drop;
	logic cls_top_queue;
	logic cls_hdr_edit;
	logic cls_ts_insert;

	assign desc_key = {desc_domain, desc_seq_id, desc_src_port};
	assign assoc_match = sync_key_valid_q && (sync_key_q == desc_key);

	// Keep the identifiers of the last Sync seen as a time-sync frame.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_key_q <= 40'h00_0000_0000;
			sync_key_valid_q <= 1'b0;
		end else if (desc_valid && cls_is_ptp && (desc_msg_type == MSG_SYNC)) begin
			sync_key_q <= desc_key;
			sync_key_valid_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Classification
	// ----------------------------------------------------------------

	// Per-frame decision logic.
	ptp_frame_classifier u_classifier (
		.cfg_one(cfg_one_q),
		.cfg_two(cfg_two_q),
		.transport(desc_transport),
		.msg_type(desc_msg_type),
		.reserved_addr(desc_reserved_addr),
		.udp_port(desc_udp_port),
		.from_host(desc_from_host),
		.same_domain(desc_same_domain),
		.from_active_master(desc_from_active_master),
		.assoc_match(assoc_match),
		.is_ptp(cls_is_ptp),
		.to_host(cls_to_host),
		.to_nonhost(cls_to_nonhost),
		.use_lookup(cls_use_lookup),
		.drop(cls_drop),
		.top_queue(cls_top_queue),
		.hdr_edit(cls_hdr_edit),
		.ts_insert(cls_ts_insert)
	);

	// Decisions are registered one cycle after the descriptor and stand until the next one.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dec_is_ptp <= 1'b0;
			dec_to_host <= 1'b0;
			dec_to_nonhost <= 1'b0;
			dec_use_lookup <= 1'b0;
			dec_drop <= 1'b0;
			dec_top_queue <= 1'b0;
			dec_hdr_edit <= 1'b0;
			dec_ts_insert <= 1'b0;
		end else if (desc_valid) begin
			dec_is_ptp <= cls_is_ptp;
			dec_to_host <= cls_to_host;
			dec_to_nonhost <= cls_to_nonhost;
			dec_use_lookup <= cls_use_lookup;
			dec_drop <= cls_drop;
			dec_top_queue <= cls_top_queue;
			dec_hdr_edit <= cls_hdr_edit;
			dec_ts_insert <= cls_ts_insert;
		end
	end

	// One-cycle strobe marking a fresh decision.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dec_valid <= 1'b0;
		end else begin
			dec_valid <= desc_valid;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_profile_gated: assert property (desc_valid && !cfg_one_q[B_SYNC_MODE] && cfg_one_q[B_PROFILE]
		|=> dec_valid && !dec_is_ptp && !dec_to_host)
		else $error("profile variant acted without time-sync mode");

	a_profile_host: assert property (desc_valid && cls_is_ptp && desc_reserved_addr
		&& cfg_one_q[B_PROFILE] |=> dec_to_host && !dec_hdr_edit)
		else $error("profile variant frame not sent to host unmodified");

	a_mode_off_plain: assert property (desc_valid && !cfg_one_q[B_SYNC_MODE]
		|=> !dec_is_ptp && dec_use_lookup && !dec_hdr_edit && !dec_ts_insert)
		else $error("frame treated as time-sync while mode off");

	a_clock_follows: assert property (wr_one_q && hwdata[B_SYNC_MODE]
		|=> ptp_clock_en && tail_tag_ts)
		else $error("clock or tail tag not enabled by mode write");

	a_eth_detect: assert property (desc_valid && (desc_transport == TR_ETH) && !cfg_one_q[B_DET_ETH]
		|=> !dec_is_ptp)
		else $error("raw Ethernet frame recognised while detection off");

	a_udp_detect: assert property (desc_valid && (((desc_transport == TR_IPV4) && !cfg_one_q[B_DET_IPV4])
		|| ((desc_transport == TR_IPV6) && !cfg_one_q[B_DET_IPV6])) |=> !dec_is_ptp)
		else $error("UDP frame recognised while detection off");

	a_unicast_lookup: assert property (desc_valid && cls_is_ptp && !desc_reserved_addr
		|=> dec_use_lookup && !dec_drop)
		else $error("unicast time-sync frame not forwarded by lookup");

	a_multicast_only: assert property (desc_valid && !cfg_two_q[B_UNICAST] && !desc_reserved_addr
		|=> !dec_is_ptp)
		else $error("unicast frame recognised with unicast disabled");

	a_queue_general: assert property (desc_valid && cls_is_ptp && !cfg_two_q[B_ALL_TOP_QUEUE]
		&& (desc_msg_type == MSG_FOLLOW_UP) |=> !dec_top_queue)
		else $error("general message placed in top queue");

	a_followup_pair: assert property (desc_valid && cls_is_ptp && desc_reserved_addr
		&& !cfg_one_q[B_PROFILE] && cfg_two_q[B_SYNC_ASSOC] && (desc_msg_type == MSG_FOLLOW_UP)
		&& !assoc_match |=> !dec_to_host)
		else $error("unmatched Follow_up sent to host");

	c_profile_frame: cover property (desc_valid && cls_is_ptp && cfg_one_q[B_PROFILE] ##1 dec_to_host);
	c_followup_match: cover property (desc_valid && cls_is_ptp && assoc_match
		&& (desc_msg_type == MSG_FOLLOW_UP));
	c_cfg_write_read: cover property (wr_two_q ##2 addr_phase && !hwrite);

endmodule : ptp_message_handling_config

// file: fabric_model.sv
// Behavioural model of the forwarding fabric that presents frame descriptors.
`timescale 1ns/100ps
module fabric_model
	import ptp_cfg_pkg::*;
(
	// Clock.
	input wire logic hclk,
	// Frame descriptor.
	output logic desc_valid,
	output transport_e desc_transport,
	output logic [3:0] desc_msg_type,
	output logic desc_reserved_addr,
	output logic [15:0] desc_udp_port,
	output logic desc_from_host,
	output logic desc_same_domain,
	output logic desc_from_active_master,
	output logic [7:0] desc_domain,
	output logic [15:0] desc_seq_id,
	output logic [15:0] desc_src_port
);
	// Nothing is presented at time zero.
	initial begin
		desc_valid = 1'b0;
		desc_transport = TR_OTHER;
		{desc_msg_type, desc_reserved_addr, desc_udp_port, desc_from_host, desc_same_domain,
			desc_from_active_master, desc_domain, desc_seq_id, desc_src_port} = 64'h0;
	end

	// Presents one descriptor for one cycle, then scrambles the fields so stale values never look valid.
	task automatic send(input transport_e t, input logic [63:0] f);
		@(posedge hclk);
		desc_valid <= 1'b1;
		desc_transport <= t;
		{desc_msg_type, desc_reserved_addr, desc_udp_port, desc_from_host, desc_same_domain,
			desc_from_active_master, desc_domain, desc_seq_id, desc_src_port} <= f;
		@(posedge hclk);
		desc_valid <= 1'b0;
		desc_transport <= transport_e'(~t);
		{desc_msg_type, desc_reserved_addr, desc_udp_port, desc_from_host, desc_same_domain,
			desc_from_active_master, desc_domain, desc_seq_id, desc_src_port} <= ~f;
	endtask : send
endmodule : fabric_model

// file: ptp_message_handling_config_tb.sv
// Self-checking testbench for the time-sync message configuration block.
`timescale 1ns/100ps
module ptp_message_handling_config_tb;
	import ptp_cfg_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, x;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic desc_valid, desc_reserved_addr, desc_from_host, desc_same_domain, desc_from_active_master;
	transport_e desc_transport;
	logic [3:0] desc_msg_type;
	logic [15:0] desc_udp_port, desc_seq_id, desc_src_port;
	logic [7:0] desc_domain;
	logic dec_valid, dec_is_ptp, dec_to_host, dec_to_nonhost, dec_use_lookup, dec_drop;
	logic dec_top_queue, dec_hdr_edit, dec_ts_insert;
	logic ptp_clock_en, tail_tag_ts, tc_p2p, host_master, one_step;
	int mismatches, checked;
	localparam logic [39:0] KEY = 40'h05123400AB;

	// ----------------------------------------------------------------
	// Design and fabric model
	// ----------------------------------------------------------------
	ptp_message_handling_config DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .desc_valid, .desc_transport, .desc_msg_type,
		.desc_reserved_addr, .desc_udp_port, .desc_from_host, .desc_same_domain, .desc_from_active_master,
		.desc_domain, .desc_seq_id, .desc_src_port, .dec_valid, .dec_is_ptp, .dec_to_host, .dec_to_nonhost,
		.dec_use_lookup, .dec_drop, .dec_top_queue, .dec_hdr_edit, .dec_ts_insert, .ptp_clock_en,
		.tail_tag_ts, .tc_p2p, .host_master, .one_step);
	fabric_model FAB (.hclk, .desc_valid, .desc_transport, .desc_msg_type, .desc_reserved_addr,
		.desc_udp_port, .desc_from_host, .desc_same_domain, .desc_from_active_master, .desc_domain,
		.desc_seq_id, .desc_src_port);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Compares one value and counts the outcome.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One AHB-Lite single transfer; read data is taken at the data-phase ready edge.
	task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {18'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? wd : 32'h0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		x = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : bus

	// Reads a register and compares it.
	task automatic rd(input string what, input logic [13:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, exp, x);
	endtask : rd

	// Sends one descriptor and compares the masked decision {ptp,host,nonhost,lookup,drop,queue,edit,ts}.
	task automatic fr(input transport_e t, input logic [3:0] m, input logic rs, input logic [15:0] p,
		input logic fh, input logic sd, input logic am, input logic [39:0] k, input logic [7:0] e,
		input logic [7:0] mk);
		FAB.send(t, {m, rs, p, fh, sd, am, k});
		#1;
		repeat (4) if (dec_valid !== 1'b1) begin
			@(posedge hclk);
			#1;
		end
		chk("dec_valid", 32'h1, {31'h0, dec_valid});
		chk("decision", {24'h0, e & mk}, {24'h0, mk & {dec_is_ptp, dec_to_host, dec_to_nonhost,
			dec_use_lookup, dec_drop, dec_top_queue, dec_hdr_edit, dec_ts_insert}});
	endtask : fr

	// Compares the static mode outputs {clock,tail,p2p,master,onestep}.
	// Looks just after the edge so that a write that landed on it is already visible.
	task automatic st(input logic [4:0] e);
		#1;
		chk("mode outputs", {27'h0, e}, {27'h0, ptp_clock_en, tail_tag_ts, tc_p2p, host_master, one_step});
	endtask : st

	// Compares everything the block shows while reset is held.
	task automatic rst_chk();
		st(5'b00001);
		chk("reset bus", 32'h2, {30'h0, hreadyout, hresp});
		chk("reset hrdata", 32'h0, hrdata);
		chk("reset decision", 32'h0, {23'h0, dec_valid, dec_is_ptp, dec_to_host, dec_to_nonhost, dec_use_lookup,
			dec_drop, dec_top_queue, dec_hdr_edit, dec_ts_insert});
	endtask : rst_chk

	// Prints the counts and the verdict, then stops.
	task automatic finish_test();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	// Free-running bus clock of 100 ns.
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	// Cuts a hang short well past the expected run time.
	initial begin
		#500us;
		mismatches++;
		finish_test();
	end

	// Main sequence.
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, hresetn} = '0;
		hsize = 3'h2;
		repeat (11) @(posedge hclk);
		rst_chk();
		@(posedge hclk);
		hresetn <= 1'b1;
		rd("cfg_one", ADDR_CFG_ONE, 32'h39);
		rd("cfg_two", ADDR_CFG_TWO, 32'h1000);
		st(5'b00001);
		bus(1'b1, ADDR_CFG_ONE, 32'hFFFFFFFE);
		rd("cfg_one", ADDR_CFG_ONE, 32'hFE);
		st(5'b11110);
		bus(1'b1, ADDR_CFG_TWO, 32'hFFFFFFFF);
		rd("cfg_two", ADDR_CFG_TWO, 32'h1E00);
		bus(1'b1, 14'h1454, 32'hFFFFFFFF);
		rd("unmapped", 14'h1454, 32'h0);
		$display("registers done");
		bus(1'b1, ADDR_CFG_ONE, 32'h39);
		bus(1'b1, ADDR_CFG_TWO, 32'h1000);
		fr(TR_ETH, MSG_SYNC, 1, 0, 0, 1, 0, KEY, 8'h10, 8'hFF);
		bus(1'b1, ADDR_CFG_ONE, 32'h79);
		st(5'b11001);
		fr(TR_ETH, MSG_SYNC, 1, 0, 0, 1, 0, KEY, 8'hE5, 8'hFD);
		fr(TR_IPV4, MSG_SYNC, 1, 16'h0141, 0, 1, 0, KEY, 8'h00, 8'h80);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, ADDR_CFG_ONE, 32'h79 ^ (32'h20 >> i));
			fr(transport_e'(i + 1), MSG_FOLLOW_UP, 1, UDP_PORT_GENERAL, 0, 1, 0, KEY, 8'h00, 8'h80);
			fr(transport_e'((i + 1) % 3 + 1), MSG_FOLLOW_UP, 1, UDP_PORT_GENERAL, 0, 1, 0, KEY, 8'h80, 8'h80);
		end
		$display("detection done");
		bus(1'b1, ADDR_CFG_ONE, 32'h79);
		fr(TR_IPV4, MSG_SYNC, 0, UDP_PORT_EVENT, 0, 1, 0, KEY, 8'h90, 8'hF8);
		bus(1'b1, ADDR_CFG_TWO, 32'h0);
		fr(TR_IPV4, MSG_SYNC, 0, UDP_PORT_EVENT, 0, 1, 0, KEY, 8'h00, 8'h80);
		bus(1'b1, ADDR_CFG_ONE, 32'hF9);
		fr(TR_ETH, MSG_FOLLOW_UP, 1, 0, 1, 1, 0, KEY, 8'hC0, 8'hD2);
		bus(1'b1, ADDR_CFG_ONE, 32'hB9);
		st(5'b00001);
		fr(TR_ETH, MSG_FOLLOW_UP, 1, 0, 1, 1, 0, KEY, 8'h00, 8'h80);
		$display("unicast and profile done");
		bus(1'b1, ADDR_CFG_ONE, 32'h79);
		bus(1'b1, ADDR_CFG_TWO, 32'h1800);
		fr(TR_ETH, MSG_SYNC, 1, 0, 0, 1, 1, KEY, 8'h20, 8'h68);
		bus(1'b1, ADDR_CFG_TWO, 32'h1000);
		fr(TR_ETH, MSG_DELAY_REQ, 1, 0, 0, 1, 1, KEY, 8'h08, 8'h68);
		fr(TR_ETH, MSG_SYNC, 1, 0, 0, 0, 1, KEY, 8'h20, 8'h68);
		fr(TR_ETH, MSG_FOLLOW_UP, 1, 0, 0, 1, 0, KEY, 8'h00, 8'h05);
		bus(1'b1, ADDR_CFG_TWO, 32'h1400);
		fr(TR_ETH, MSG_FOLLOW_UP, 1, 0, 0, 1, 0, KEY, 8'h04, 8'h05);
		$display("alternate master and queue done");
		bus(1'b1, ADDR_CFG_TWO, 32'h1200);
		fr(TR_ETH, MSG_SYNC, 1, 0, 0, 1, 0, KEY ^ 40'h2, 8'h80, 8'h80);
		fr(TR_ETH, MSG_FOLLOW_UP, 1, 0, 0, 1, 0, KEY ^ 40'h2, 8'h40, 8'h40);
		fr(TR_ETH, MSG_FOLLOW_UP, 1, 0, 0, 1, 0, KEY, 8'h00, 8'h40);
		$display("association done");
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		rst_chk();
		@(posedge hclk);
		hresetn <= 1'b1;
		rd("cfg_one", ADDR_CFG_ONE, 32'h39);
		rd("cfg_two", ADDR_CFG_TWO, 32'h1000);
		$display("reset done");
		finish_test();
	end
endmodule : ptp_message_handling_config_tb
